// ### design/bbx_exec.sv
// Contract
// - Register bit forms: 0000,reg,111/100,ea
// - Immediate bit forms: 11/00, extension upper byte zero
// - Test-and-set only on data-alterable destinations
// - Bit ops set Z from bit, others kept
// - Branch: push next address at SP minus 4
// - Branch base is opcode address plus two
// - Short field picks byte, word or long displacement
// - Displacement is signed byte distance from base
// - Register bit modulo 32, memory modulo 8
// - Bit number from extension or register; test keeps
// - Bit test accepts data modes and PC-relative
// - Single bound traps vector 6 outside range
// - Single bound sets N low, clears high
// - Single bound decode: reg, size 11/10, bit6 zero
// - Single bound operand: data modes, no address reg
// - Bounds pair: lower then upper, three sizes
// - Pair: data low part, address extended bounds
// - Pair traps vector 6 outside inclusive range
// - Pair sets Z on equal, C out of bounds
// - Pair register from extension selector bit
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module bbx_exec (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic NRST,
	// Write address channel
	input wire logic [bbx_pkg::AW-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// Write data channel
	input wire logic [bbx_pkg::DW-1:0] S_AXI_WDATA,
	input wire logic [bbx_pkg::SW-1:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// Write response channel
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// Read address channel
	input wire logic [bbx_pkg::AW-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// Read data channel
	output logic [bbx_pkg::DW-1:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Exception sequencer request
	output logic EXC_REQ,
	output logic [bbx_pkg::VW-1:0] EXC_VEC
);
	import bbx_pkg::*;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Byte-lane merge for strobed writes
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] o,
		input logic [DW-1:0] d, input logic [SW-1:0] s);
		logic [DW-1:0] r;
		r = o;
		for (int i = 0; i < SW; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Data modes; immediate and PC-relative optional
	function automatic logic ea_data(input logic [2:0] m,
		input logic [2:0] r, input logic imm_ok, input logic pc_ok);
		logic ok;
		ok = 1'b1;
		if (m == M_AREG) begin
			ok = 1'b0;
		end else if (m == M_EXT) begin
			ok = (r == R_ABSW) | (r == R_ABSL) |
				(pc_ok & ((r == R_PCD) | (r == R_PCX))) |
				(imm_ok & (r == R_IMM));
		end
		return ok;
	endfunction : ea_data

	// Control modes only
	function automatic logic ea_ctl(input logic [2:0] m,
		input logic [2:0] r);
		return (m == M_IND) | (m == M_DISP) | (m == M_IDX) |
			((m == M_EXT) & (r <= R_PCX));
	endfunction : ea_ctl

	// Fit a value to a size, sign or zero extended
	function automatic logic [31:0] fit(input logic [31:0] v,
		input logic [1:0] sz, input logic sgn);
		logic [31:0] r;
		r = v;
		if (sz == SZ_B) begin
			r = {{24{sgn & v[7]}}, v[7:0]};
		end else if (sz == SZ_W) begin
			r = {{16{sgn & v[15]}}, v[15:0]};
		end
		return r;
	endfunction : fit

	// Replace one flag
	function automatic logic [CW-1:0] flag(input logic [CW-1:0] c,
		input int p, input logic v);
		logic [CW-1:0] r;
		r = c;
		r[p] = v;
		return r;
	endfunction : flag

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic awv_ff, wv_ff, awready_ff, wready_ff, bvalid_ff;
	logic arready_ff, rvalid_ff;
	logic [AW-1:0] awaddr_ff; // Held write address
	logic [DW-1:0] wdata_ff; // Held write data
	logic [SW-1:0] wstrb_ff; // Held strobes
	logic [1:0] bresp_ff, rresp_ff;
	logic [DW-1:0] rdata_ff;
	logic [OPW-1:0] opcode_ff; // Opcode word
	logic [DW-1:0] ext_ff; // Extension words
	logic [DW-1:0] dest_ff; // Destination or checked value
	logic [DW-1:0] aux_ff; // Bit register or lower bound
	logic [DW-1:0] upper_ff; // Upper bound operand
	logic [DW-1:0] pc_ff, sp_ff;
	logic [CW-1:0] ccr_in_ff;
	logic go_ff; // Execute this cycle
	logic done_ff, ill_ff, trap_ff, wdest_ff, push_ff;
	logic [DW-1:0] result_ff, newpc_ff, newsp_ff, pushd_ff;
	logic [CW-1:0] ccr_ff;
	logic exc_req_ff;
	logic [VW-1:0] exc_vec_ff;

	// ----------------------------------------
	// Write path
	// ----------------------------------------
	wire aw_ok = S_AXI_AWVALID & awready_ff;
	wire w_ok = S_AXI_WVALID & wready_ff;
	wire do_wr = awv_ff & wv_ff & ~bvalid_ff;
	wire nxt_awv = (awv_ff | aw_ok) & ~do_wr;
	wire nxt_wv = (wv_ff | w_ok) & ~do_wr;
	wire nxt_bv = do_wr | (bvalid_ff & ~S_AXI_BREADY);
	wire wr_hit = awaddr_ff <= REG_CCR_IN;
	wire [DW-1:0] wr_old;
	wire [DW-1:0] wr_val = merge(wr_old, wdata_ff, wstrb_ff);
	wire start = do_wr & (awaddr_ff == REG_CTRL) & wr_val[CTRL_GO];

	// Channel handshake state
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			awv_ff <= 1'b0;
			wv_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= RESP_OKAY;
			awaddr_ff <= '0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
		end else begin
			awv_ff <= nxt_awv;
			wv_ff <= nxt_wv;
			awready_ff <= ~nxt_awv;
			wready_ff <= ~nxt_wv;
			bvalid_ff <= nxt_bv;
			if (aw_ok) begin // Catch address
				awaddr_ff <= S_AXI_AWADDR;
			end
			if (w_ok) begin // Catch data
				wdata_ff <= S_AXI_WDATA;
				wstrb_ff <= S_AXI_WSTRB;
			end
			if (do_wr) begin // Offsets above REG_CCR_IN get SLVERR
				bresp_ff <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Operand registers written by software
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			opcode_ff <= '0;
			ext_ff <= '0;
			dest_ff <= '0;
			aux_ff <= '0;
			upper_ff <= '0;
			pc_ff <= '0;
			sp_ff <= '0;
			ccr_in_ff <= '0;
		end else if (do_wr) begin
			case (awaddr_ff)
				REG_OPCODE: opcode_ff <= wr_val[OPW-1:0];
				REG_EXT: ext_ff <= wr_val;
				REG_DEST: dest_ff <= wr_val;
				REG_AUX: aux_ff <= wr_val;
				REG_UPPER: upper_ff <= wr_val;
				REG_PC: pc_ff <= wr_val;
				REG_SP: sp_ff <= wr_val;
				REG_CCR_IN: ccr_in_ff <= wr_val[CW-1:0];
				default: ; // Control and read-only
			endcase
		end
	end

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	wire [2:0] mode = opcode_ff[5:3];
	wire [2:0] ereg = opcode_ff[2:0];
	wire is_dyn = (opcode_ff[15:12] == BIT_TOP) &
		((opcode_ff[8:6] == BIT_SET_OP) | (opcode_ff[8:6] == BIT_TST_OP));
	wire is_imm = (opcode_ff[15:8] == BIT_IMM_HI) &
		((opcode_ff[7:6] == IMM_SET) | (opcode_ff[7:6] == IMM_TST)) &
		(ext_ff[15:8] == '0);
	wire bit_set = is_dyn ? (opcode_ff[8:6] == BIT_SET_OP) :
		(opcode_ff[7:6] == IMM_SET);
	// Test-and-set: no PC-relative, no immediate
	wire bit_ok = (is_dyn | is_imm) &
		ea_data(mode, ereg, ~bit_set & is_dyn, ~bit_set);
	wire is_branch = opcode_ff[15:8] == BRANCH_HI;
	wire [1:0] one_sz = opcode_ff[8:7];
	wire one_ok = (opcode_ff[15:12] == ONE_TOP) & ~opcode_ff[6] &
		((one_sz == ONE_SZ_W) | (one_sz == ONE_SZ_L)) &
		ea_data(mode, ereg, 1'b1, 1'b1);
	wire [1:0] two_sz = opcode_ff[10:9];
	wire two_ok = (opcode_ff[15:11] == TWO_TOP) &
		(opcode_ff[8:6] == TWO_OP) & (two_sz != SZ_BAD) &
		(ext_ff[11:0] == TWO_EXT_LO) & ea_ctl(mode, ereg);
	wire legal = bit_ok | is_branch | one_ok | two_ok;

	// ----------------------------------------
	// Bit test and set
	// ----------------------------------------
	// Bit number source
	wire [DW-1:0] bitnum = is_dyn ? aux_ff : ext_ff;
	wire [4:0] idx = (mode == M_DREG) ? bitnum[4:0] :
		{2'h0, bitnum[2:0]};
	wire [DW-1:0] mask = 32'h1 << idx;
	wire tbit = |(dest_ff & mask);
	// Test leaves destination as it was
	wire [DW-1:0] bit_res = bit_set ? (dest_ff | mask) : dest_ff;

	// ----------------------------------------
	// Branch to subroutine
	// ----------------------------------------
	wire [7:0] d8 = opcode_ff[7:0];
	wire [DW-1:0] base = pc_ff + PC_STEP;
	wire [DW-1:0] disp = (d8 == DISP_WORD) ? fit(ext_ff, SZ_W, 1'b1) :
		(d8 == DISP_LONG) ? ext_ff : {{24{d8[7]}}, d8};
	wire [DW-1:0] extlen = (d8 == DISP_WORD) ? EXT_WORD :
		(d8 == DISP_LONG) ? EXT_LONG : '0;
	wire [DW-1:0] br_pc = base + disp;
	wire [DW-1:0] br_ret = base + extlen;
	wire [DW-1:0] br_sp = sp_ff - SP_STEP;

	// ----------------------------------------
	// Single bound check
	// ----------------------------------------
	wire one_long = one_sz == ONE_SZ_L;
	wire [DW-1:0] one_v = one_long ? dest_ff : fit(dest_ff, SZ_W, 1'b1);
	wire [DW-1:0] one_b = one_long ? upper_ff : fit(upper_ff, SZ_W, 1'b1);
	wire one_neg = one_v[DW-1];
	wire one_over = ~one_neg & ($signed(one_v) > $signed(one_b));

	// ----------------------------------------
	// Bounds pair check
	// ----------------------------------------
	wire two_areg = ext_ff[TWO_AREG];
	wire [DW-1:0] lb = fit(aux_ff, two_sz, two_areg);
	wire [DW-1:0] ub = fit(upper_ff, two_sz, two_areg);
	wire [DW-1:0] rv = two_areg ? dest_ff : fit(dest_ff, two_sz, 1'b0);
	// Inverted pair wraps around the top of the range
	wire two_out = (lb <= ub) ? ((rv < lb) | (rv > ub)) :
		((rv < lb) & (rv > ub));
	wire two_eq = (rv == lb) | (rv == ub);

	// ----------------------------------------
	// Results
	// ----------------------------------------
	wire trap = (one_ok & (one_neg | one_over)) | (two_ok & two_out);
	wire [CW-1:0] ccr_one = one_neg ? flag(ccr_in_ff, F_N, 1'b1) :
		one_over ? flag(ccr_in_ff, F_N, 1'b0) : ccr_in_ff;
	wire [CW-1:0] ccr_two = flag(flag(ccr_in_ff, F_Z, two_eq),
		F_C, two_out);
	wire [CW-1:0] nxt_ccr = bit_ok ? flag(ccr_in_ff, F_Z, ~tbit) :
		one_ok ? ccr_one : two_ok ? ccr_two : ccr_in_ff;

	// Capture on execute
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			go_ff <= 1'b0;
			done_ff <= 1'b0;
			ill_ff <= 1'b0;
			trap_ff <= 1'b0;
			wdest_ff <= 1'b0;
			push_ff <= 1'b0;
			result_ff <= '0;
			newpc_ff <= '0;
			newsp_ff <= '0;
			pushd_ff <= '0;
			ccr_ff <= '0;
			exc_req_ff <= 1'b0;
			exc_vec_ff <= '0;
		end else begin
			go_ff <= start;
			exc_req_ff <= go_ff & trap;
			if (start) begin // New run clears done
				done_ff <= 1'b0;
			end
			if (go_ff) begin
				done_ff <= 1'b1;
				ill_ff <= ~legal;
				trap_ff <= trap;
				wdest_ff <= bit_ok & bit_set;
				push_ff <= is_branch;
				result_ff <= bit_res;
				newpc_ff <= is_branch ? br_pc : pc_ff;
				newsp_ff <= is_branch ? br_sp : sp_ff;
				pushd_ff <= br_ret;
				ccr_ff <= nxt_ccr;
				exc_vec_ff <= trap ? VEC_BOUNDS : '0;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	wire [DW-1:0] status = {16'h0, exc_vec_ff, 3'h0, push_ff, wdest_ff,
		trap_ff, ill_ff, done_ff};
	// Register read selection
	function automatic logic [DW-1:0] rd_sel(input logic [AW-1:0] a);
		case (a)
			REG_OPCODE: return {16'h0, opcode_ff};
			REG_EXT: return ext_ff;
			REG_DEST: return dest_ff;
			REG_AUX: return aux_ff;
			REG_UPPER: return upper_ff;
			REG_PC: return pc_ff;
			REG_SP: return sp_ff;
			REG_CCR_IN: return {27'h0, ccr_in_ff};
			REG_STATUS: return status;
			REG_RESULT: return result_ff;
			REG_NEWPC: return newpc_ff;
			REG_NEWSP: return newsp_ff;
			REG_PUSH: return pushd_ff;
			REG_CCR_OUT: return {27'h0, ccr_ff};
			default: return '0;
		endcase
	endfunction : rd_sel
	assign wr_old = rd_sel(awaddr_ff);
	wire ar_ok = S_AXI_ARVALID & arready_ff;
	wire nxt_rv = ar_ok | (rvalid_ff & ~S_AXI_RREADY);
	wire [DW-1:0] rd_val = rd_sel(S_AXI_ARADDR);
	wire rd_hit = S_AXI_ARADDR <= REG_CCR_OUT;

	// Read channel state
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= '0;
			rresp_ff <= RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rv;
			rvalid_ff <= nxt_rv;
			if (ar_ok) begin
				rdata_ff <= rd_val;
				rresp_ff <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Port drive
	assign S_AXI_AWREADY = awready_ff;
	assign S_AXI_WREADY = wready_ff;
	assign S_AXI_BRESP = bresp_ff;
	assign S_AXI_BVALID = bvalid_ff;
	assign S_AXI_ARREADY = arready_ff;
	assign S_AXI_RDATA = rdata_ff;
	assign S_AXI_RRESP = rresp_ff;
	assign S_AXI_RVALID = rvalid_ff;
	assign EXC_REQ = exc_req_ff;
	assign EXC_VEC = exc_vec_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_set_marks_bit: assert property (
		go_ff && bit_ok && bit_set |=> result_ff == ($past(dest_ff) |
		$past(mask)) && wdest_ff)
		else $error("set bit not written");
	a_test_keeps_dest: assert property (
		go_ff && bit_ok && !bit_set |=> result_ff == $past(dest_ff)
		&& !wdest_ff)
		else $error("bit test modified destination");
	a_bit_zero_flag: assert property (
		go_ff && bit_ok |=> ccr_ff[F_Z] == !$past(dest_ff[idx]) &&
		ccr_ff[F_C] == $past(ccr_in_ff[F_C]))
		else $error("bit test flags wrong");
	a_mem_mod_eight: assert property (
		bit_ok && mode != M_DREG |-> mask[DW-1:8] == '0 &&
		mask[bitnum[2:0]])
		else $error("memory bit beyond byte");
	a_set_rejects_areg: assert property (
		go_ff && (is_dyn || is_imm) && bit_set && mode == M_AREG
		|=> ill_ff)
		else $error("address register accepted");
	a_branch_stack: assert property (
		go_ff && is_branch |=> newsp_ff == $past(sp_ff) - SP_STEP &&
		ccr_ff == $past(ccr_in_ff))
		else $error("stack step wrong");
	a_branch_short: assert property (
		go_ff && is_branch && d8 != DISP_WORD && d8 != DISP_LONG |=>
		newpc_ff == $past(pc_ff) + PC_STEP + {{24{$past(d8[7])}},
		$past(d8)} && pushd_ff == $past(pc_ff) + PC_STEP)
		else $error("short branch target wrong");
	a_branch_word: assert property (
		go_ff && is_branch && d8 == DISP_WORD |=> pushd_ff ==
		$past(pc_ff) + PC_STEP + EXT_WORD)
		else $error("word branch return wrong");
	a_one_neg_trap: assert property (
		go_ff && one_ok && one_neg |=> trap_ff && ccr_ff[F_N] &&
		EXC_REQ && EXC_VEC == VEC_BOUNDS ##1 !EXC_REQ)
		else $error("negative value did not trap");
	a_one_over_n: assert property (
		go_ff && one_ok && one_over |=> !ccr_ff[F_N] && trap_ff)
		else $error("upper bound miss");
	a_two_equal: assert property (
		go_ff && two_ok && lb == ub && rv == lb |=> !trap_ff &&
		ccr_ff[F_Z] && !ccr_ff[F_C])
		else $error("single value range trapped");
	a_two_carry: assert property (
		go_ff && two_ok |=> ccr_ff[F_C] == trap_ff)
		else $error("carry does not follow trap");
endmodule : bbx_exec
`default_nettype wire

// ### design/bbx_pkg.sv
`default_nettype none
package bbx_pkg;
	// ----------------------------------------
	// Bus widths
	// ----------------------------------------
	localparam int AW = 8;
	localparam int DW = 32;
	localparam int SW = 4;
	localparam int OPW = 16;
	localparam int CW = 5;
	localparam int VW = 8;
	// ----------------------------------------
	// Register byte offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_OPCODE = 8'h04;
	localparam logic [7:0] REG_EXT = 8'h08;
	localparam logic [7:0] REG_DEST = 8'h0C;
	localparam logic [7:0] REG_AUX = 8'h10;
	localparam logic [7:0] REG_UPPER = 8'h14;
	localparam logic [7:0] REG_PC = 8'h18;
	localparam logic [7:0] REG_SP = 8'h1C;
	localparam logic [7:0] REG_CCR_IN = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_RESULT = 8'h28;
	localparam logic [7:0] REG_NEWPC = 8'h2C;
	localparam logic [7:0] REG_NEWSP = 8'h30;
	localparam logic [7:0] REG_PUSH = 8'h34;
	localparam logic [7:0] REG_CCR_OUT = 8'h38;
	// ----------------------------------------
	// Field bit positions
	// ----------------------------------------
	localparam int CTRL_GO = 0;
	localparam int ST_DONE = 0;
	localparam int ST_ILL = 1;
	localparam int ST_TRAP = 2;
	localparam int ST_WDEST = 3;
	localparam int ST_PUSH = 4;
	localparam int F_C = 0;
	localparam int F_V = 1;
	localparam int F_Z = 2;
	localparam int F_N = 3;
	localparam int TWO_AREG = 15;
	// ----------------------------------------
	// Opcode codes
	// ----------------------------------------
	localparam logic [3:0] BIT_TOP = 4'h0;
	localparam logic [2:0] BIT_SET_OP = 3'h7;
	localparam logic [2:0] BIT_TST_OP = 3'h4;
	localparam logic [7:0] BIT_IMM_HI = 8'h08;
	localparam logic [1:0] IMM_SET = 2'h3;
	localparam logic [1:0] IMM_TST = 2'h0;
	localparam logic [7:0] BRANCH_HI = 8'h61;
	localparam logic [7:0] DISP_WORD = 8'h00;
	localparam logic [7:0] DISP_LONG = 8'hFF;
	localparam logic [3:0] ONE_TOP = 4'h4;
	localparam logic [1:0] ONE_SZ_W = 2'h3;
	localparam logic [1:0] ONE_SZ_L = 2'h2;
	localparam logic [4:0] TWO_TOP = 5'h00;
	localparam logic [2:0] TWO_OP = 3'h3;
	localparam logic [11:0] TWO_EXT_LO = 12'h800;
	localparam logic [1:0] SZ_B = 2'h0;
	localparam logic [1:0] SZ_W = 2'h1;
	localparam logic [1:0] SZ_BAD = 2'h3;
	// ----------------------------------------
	// Effective address modes
	// ----------------------------------------
	localparam logic [2:0] M_DREG = 3'h0;
	localparam logic [2:0] M_AREG = 3'h1;
	localparam logic [2:0] M_IND = 3'h2;
	localparam logic [2:0] M_DISP = 3'h5;
	localparam logic [2:0] M_IDX = 3'h6;
	localparam logic [2:0] M_EXT = 3'h7;
	localparam logic [2:0] R_ABSW = 3'h0;
	localparam logic [2:0] R_ABSL = 3'h1;
	localparam logic [2:0] R_PCD = 3'h2;
	localparam logic [2:0] R_PCX = 3'h3;
	localparam logic [2:0] R_IMM = 3'h4;
	// ----------------------------------------
	// Arithmetic constants and answers
	// ----------------------------------------
	localparam logic [7:0] VEC_BOUNDS = 8'h06;
	localparam logic [31:0] SP_STEP = 32'h4;
	localparam logic [31:0] PC_STEP = 32'h2;
	localparam logic [31:0] EXT_WORD = 32'h2;
	localparam logic [31:0] EXT_LONG = 32'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bbx_pkg
`default_nettype wire

// ### bench/bbx_exc_seq.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Exception sequencer model
// ----------------------------------------
module bbx_exc_seq (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Request from the block
	input wire logic exc_req,
	input wire logic [7:0] exc_vec,
	// Tally for the bench
	output logic [7:0] trap_cnt,
	output logic [7:0] last_vec
);
	// Counts check requests, keeps the vector it was given
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			trap_cnt <= 8'h00;
			last_vec <= 8'h00;
		end else if (exc_req) begin
			trap_cnt <= trap_cnt + 8'h01;
			last_vec <= exc_vec;
		end
	end
endmodule : bbx_exc_seq
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bbx_pkg::*;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clk, nrst;
	logic [AW-1:0] awaddr, araddr;
	logic [DW-1:0] wdata, rdata, rd_val;
	logic [SW-1:0] wstrb;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, exc_req;
	logic [1:0] bresp, rresp, resp;
	logic [VW-1:0] exc_vec, trap_cnt, last_vec;
	int fail_count, comparisons, exp_traps;
	// Encodings that must be refused
	logic [15:0] bad_ops [6] = '{16'h01C8, 16'h01FA, 16'h01FC,
		16'h083C, 16'h4189, 16'h08C8};
	// ----------------------------------------
	// Design and partner
	// ----------------------------------------
	bbx_exec dut_u (.CLK_SYS(clk), .NRST(nrst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .EXC_REQ(exc_req), .EXC_VEC(exc_vec));
	bbx_exc_seq seq_u (.clk_sys(clk), .nrst(nrst), .exc_req(exc_req),
		.exc_vec(exc_vec), .trap_cnt(trap_cnt), .last_vec(last_vec));
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	// One write, address and data offered together
	task wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			// Each channel released when taken
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1 && n < 100);
		resp = bresp;
		if (n >= 100) begin
			fail_count++;
			$display("ERROR %0t: write not answered", $time);
		end
		bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	// One read, data taken at the answering edge
	task rd(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1 && n < 100);
		rd_val = rdata;
		resp = rresp;
		if (n >= 100) begin
			fail_count++;
			$display("ERROR %0t: read not answered", $time);
		end
		rready <= 1'b0;
		@(posedge clk);
	endtask : rd
	// ----------------------------------------
	// Compare tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: value %h expected %h", $time, got, exp);
		end
	endtask : chk
	task chk_resp(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t: response %h expected %h", $time, got, exp);
		end
	endtask : chk_resp
	// Read one register and compare
	task look(input logic [7:0] a, input logic [31:0] exp);
		rd(a);
		chk(rd_val, exp);
	endtask : look
	// ----------------------------------------
	// Execute one instruction and check status
	// ----------------------------------------
	task ex(input logic [15:0] op, input logic [31:0] ext, dst, aux,
		upr, input logic [4:0] ccr, input logic [15:0] st,
		input logic [4:0] cc);
		int n;
		n = 0;
		wr(REG_OPCODE, {16'h0000, op});
		wr(REG_EXT, ext);
		wr(REG_DEST, dst);
		wr(REG_AUX, aux);
		wr(REG_UPPER, upr);
		wr(REG_PC, 32'h0000_1000);
		wr(REG_SP, 32'h0000_2000);
		wr(REG_CCR_IN, {27'h0000000, ccr});
		wr(REG_CTRL, 32'h0000_0001);
		// Poll until done, bounded
		do begin
			rd(REG_STATUS);
			n++;
		end while (rd_val[ST_DONE] !== 1'b1 && n < 20);
		// Let the trap pulse reach the sequencer
		repeat (3) @(posedge clk);
		chk({16'h0000, rd_val[15:0]}, {16'h0000, st});
		look(REG_CCR_OUT, {27'h0000000, cc});
		if (st[ST_TRAP]) exp_traps++;
		chk({24'h000000, trap_cnt}, 32'(exp_traps));
		chk({24'h000000, exc_vec}, st[ST_TRAP] ? 32'h6 : 32'h0);
	endtask : ex
	// Branch run, checks target, stack and return address
	task br(input logic [15:0] op, input logic [31:0] ext, npc, ret);
		ex(op, ext, 32'h0, 32'h0, 32'h0, 5'h1F, 16'h0011, 5'h1F);
		look(REG_NEWPC, npc);
		look(REG_NEWSP, 32'h0000_1FFC);
		look(REG_PUSH, ret);
	endtask : br
	// Verdict and end of run
	task wrap_up;
		$display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		fail_count = 0;
		comparisons = 0;
		exp_traps = 0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		// Unmapped accesses answer with an error
		rd(8'h40);
		chk(rd_val, 32'h0);
		chk_resp(resp, RESP_SLVERR);
		wr(8'h3C, 32'h1234_5678);
		chk_resp(resp, RESP_SLVERR);
		// Branch sizes: byte, negative byte, word, long
		br(16'h6110, 32'h0, 32'h0000_1012, 32'h0000_1002);
		br(16'h61F0, 32'h0, 32'h0000_0FF2, 32'h0000_1002);
		br(16'h6100, 32'h0000_FFFE, 32'h0000_1000, 32'h0000_1004);
		br(16'h61FF, 32'h0000_0100, 32'h0000_1102, 32'h0000_1006);
		// Read-only place refuses writes and keeps its value
		wr(REG_NEWPC, 32'hDEAD_BEEF);
		chk_resp(resp, RESP_SLVERR);
		look(REG_NEWPC, 32'h0000_1102);
		// Bit forms on registers and memory
		ex(16'h03C0, 32'h0, 32'h8000_0000, 32'h21, 32'h0, 5'h1B, 16'h0009,
			5'h1F);
		look(REG_RESULT, 32'h8000_0002);
		ex(16'h03C0, 32'h0, 32'h8000_0000, 32'h1F, 32'h0, 5'h04, 16'h0009,
			5'h00);
		look(REG_RESULT, 32'h8000_0000);
		ex(16'h08D0, 32'h000B, 32'h0, 32'h0, 32'h0, 5'h00, 16'h0009,
			5'h04);
		look(REG_RESULT, 32'h0000_0008);
		ex(16'h0800, 32'h0005, 32'h20, 32'h0, 32'h0, 5'h04, 16'h0001,
			5'h00);
		ex(16'h013C, 32'h0, 32'h04, 32'h22, 32'h0, 5'h00, 16'h0001,
			5'h00);
		ex(16'h013A, 32'h0, 32'h0, 32'h0, 32'h0, 5'h00, 16'h0001,
			5'h04);
		// Refused encodings leave flags alone
		foreach (bad_ops[i]) begin
			ex(bad_ops[i], 32'h0, 32'h0, 32'h0, 32'h0, 5'h15, 16'h0003,
				5'h15);
		end
		// Single bound: negative word, above long, at bound
		ex(16'h4181, 32'h0, 32'h0000_FFFF, 32'h0, 32'h10, 5'h00, 16'h0605,
			5'h08);
		ex(16'h4101, 32'h0, 32'h5, 32'h0, 32'h4, 5'h08, 16'h0605,
			5'h00);
		ex(16'h413C, 32'h0, 32'h4, 32'h0, 32'h4, 5'h0F, 16'h0001,
			5'h0F);
		// Bounds pair over sizes and register kinds
		ex(16'h00D0, 32'h0800, 32'h1234_5610, 32'h10, 32'h20, 5'h10,
			16'h0001, 5'h14);
		ex(16'h02D0, 32'h1800, 32'h0001_0030, 32'h10, 32'h20, 5'h10,
			16'h0605, 5'h11);
		ex(16'h02D0, 32'h8800, 32'hFFFF_FFF0, 32'hFFF0, 32'h10, 5'h10,
			16'h0001, 5'h14);
		ex(16'h02D0, 32'h8800, 32'h0001_0000, 32'hFFF0, 32'h10, 5'h10,
			16'h0605, 5'h11);
		ex(16'h04D0, 32'h0800, 32'h7, 32'h7, 32'h7, 5'h00, 16'h0001,
			5'h04);
		ex(16'h04D0, 32'h0800, 32'h8, 32'h7, 32'h7, 5'h00, 16'h0605,
			5'h01);
		chk({24'h000000, last_vec}, {24'h000000, VEC_BOUNDS});
		wrap_up();
	end
endmodule : tb
`default_nettype wire
